//--- verilog/dsw_pkg.sv
// constants shared by the decrement, skip, jump and watchdog-kick execute block
// assumes a 14-bit instruction word and an 8-bit data path
package dsw_pkg;
    localparam int unsigned DSW_INSTR_W     = 14;
    localparam int unsigned DSW_DATA_W      = 8;
    localparam int unsigned DSW_FADDR_W     = 7;
    localparam int unsigned DSW_PC_W        = 13;
    localparam int unsigned DSW_JUMP_W      = 11;
    localparam int unsigned DSW_REG_COUNT   = 128;
    localparam int unsigned DSW_AV_ADDR_W   = 4;
    localparam int unsigned DSW_AV_DATA_W   = 32;

    // opcode patterns, destination bit and the latch bits used by jump
    localparam logic [13:0] DSW_KICK_CODE   = 14'h0064;
    localparam logic [5:0]  DSW_DEC_CODE    = 6'h03;
    localparam logic [5:0]  DSW_DECSZ_CODE  = 6'h0B;
    localparam logic [2:0]  DSW_JUMP_CODE   = 3'h5;
    localparam int unsigned DSW_DEST_BIT    = 7;
    localparam int unsigned DSW_LATCH_HI    = 4;
    localparam int unsigned DSW_LATCH_LO    = 3;

    // values and reset values
    localparam logic [7:0]  DSW_ONE         = 8'h01;
    localparam logic [7:0]  DSW_BYTE_ZERO   = 8'h00;
    localparam logic [7:0]  DSW_BYTE_FULL   = 8'hFF;
    localparam logic [12:0] DSW_PC_RESET    = 13'h0000;
    localparam logic [12:0] DSW_PC_STEP     = 13'h0001;

    // register word addresses
    localparam logic [3:0]  DSW_REG_LATCH   = 4'h0;
    localparam logic [3:0]  DSW_REG_STATUS  = 4'h1;
    localparam logic [3:0]  DSW_REG_WORK    = 4'h2;
    localparam logic [3:0]  DSW_REG_PC      = 4'h3;
    localparam logic [3:0]  DSW_REG_WDOG    = 4'h4;
    localparam logic [3:0]  DSW_REG_FINDEX  = 4'h5;
    localparam logic [3:0]  DSW_REG_FDATA   = 4'h6;

    // status register bit positions and the prescaler position in the watchdog word
    localparam int unsigned DSW_ST_ZERO     = 0;
    localparam int unsigned DSW_ST_SLEEP    = 1;
    localparam int unsigned DSW_ST_EXPIRY   = 2;
    localparam int unsigned DSW_ST_FLUSH    = 3;
    localparam int unsigned DSW_WD_PRE_LSB  = 8;

    typedef enum logic [2:0] {
        DSW_OP_NONE,
        DSW_OP_KICK,
        DSW_OP_DEC,
        DSW_OP_DECSZ,
        DSW_OP_JUMP
    } dsw_op_e;

    typedef enum logic {
        DSW_ST_EXEC,
        DSW_ST_FLUSHING
    } dsw_state_e;
endpackage : dsw_pkg

//--- verilog/dsw_core.sv
// execute block for watchdog kick, decrement, decrement-skip and jump
// assumes an outside fetch stage presenting one instruction per cycle with a valid,
// and an Avalon-MM master reaching the registers
//
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module dsw_core
    import dsw_pkg::*;
(
    // clock and reset
    input  wire logic                     i_core_clk,
    input  wire logic                     i_sys_rst,
    // instruction stream
    input  wire logic [DSW_INSTR_W-1:0]   i_instr,
    input  wire logic                     i_instr_valid,
    input  wire logic                     i_sleep_enter,
    // avalon-mm slave
    input  wire logic [DSW_AV_ADDR_W-1:0] i_avs_address,
    input  wire logic                     i_avs_read,
    input  wire logic                     i_avs_write,
    input  wire logic [DSW_AV_DATA_W-1:0] i_avs_writedata,
    output logic      [DSW_AV_DATA_W-1:0] o_avs_readdata,
    output logic                          o_avs_waitrequest,
    // core state
    output logic      [DSW_PC_W-1:0]      o_pc,
    output logic      [DSW_DATA_W-1:0]    o_work,
    output logic                          o_zero_flag,
    output logic                          o_watchdog_expiry_flag,
    output logic                          o_sleep_entry_flag,
    output logic      [DSW_DATA_W-1:0]    o_watchdog_counter,
    output logic      [DSW_DATA_W-1:0]    o_watchdog_prescaler,
    output logic                          o_flush
);

    logic [DSW_DATA_W-1:0]  data_regs [DSW_REG_COUNT];
    logic [DSW_DATA_W-1:0]  pc_upper_latch;
    logic [DSW_FADDR_W-1:0] findex;
    dsw_state_e             state;
    dsw_op_e                op;
    logic                   exec;
    logic [DSW_FADDR_W-1:0] faddr;
    logic                   dest_reg;
    logic [DSW_DATA_W-1:0]  dec_result;
    logic                   dec_zero;
    logic                   bus_take;
    logic [DSW_PC_W-1:0]    jump_target;

    // instruction classifier
    function automatic dsw_op_e decode_op(input logic [DSW_INSTR_W-1:0] word);
        dsw_op_e kind;
        kind = DSW_OP_NONE;
        if (word == DSW_KICK_CODE) begin
            kind = DSW_OP_KICK;
        end else if (word[DSW_INSTR_W-1 -: $bits(DSW_DEC_CODE)] == DSW_DEC_CODE) begin
            kind = DSW_OP_DEC;
        end else if (word[DSW_INSTR_W-1 -: $bits(DSW_DECSZ_CODE)] == DSW_DECSZ_CODE) begin
            kind = DSW_OP_DECSZ;
        end else if (word[DSW_INSTR_W-1 -: $bits(DSW_JUMP_CODE)] == DSW_JUMP_CODE) begin
            kind = DSW_OP_JUMP;
        end
        return kind;
    endfunction : decode_op

    // decode and operand fetch; flushed slot executes nothing
    assign exec        = i_instr_valid && (state == DSW_ST_EXEC);
    assign op          = exec ? decode_op(i_instr) : DSW_OP_NONE;
    assign faddr       = i_instr[DSW_FADDR_W-1:0];
    assign dest_reg    = i_instr[DSW_DEST_BIT];
    assign dec_result  = data_regs[faddr] - DSW_ONE;
    assign dec_zero    = (dec_result == DSW_BYTE_ZERO);
    assign jump_target = {pc_upper_latch[DSW_LATCH_HI:DSW_LATCH_LO],
                          i_instr[DSW_JUMP_W-1:0]};
    assign bus_take    = (i_avs_read || i_avs_write) && !o_avs_waitrequest;

    // sequencing: jump and taken skip spend one more cycle on a discarded word
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state   <= DSW_ST_EXEC;
            o_flush <= 1'b0;
        end else begin
            unique case (state)
                DSW_ST_EXEC: begin
                    if (op == DSW_OP_JUMP || (op == DSW_OP_DECSZ && dec_zero)) begin
                        state   <= DSW_ST_FLUSHING;
                        o_flush <= 1'b1;
                    end else begin
                        o_flush <= 1'b0;
                    end
                end
                DSW_ST_FLUSHING: begin
                    state   <= DSW_ST_EXEC;
                    o_flush <= 1'b0;
                end
            endcase
        end
    end

    // program counter
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pc <= DSW_PC_RESET;
        end else if (op == DSW_OP_JUMP) begin
            o_pc <= jump_target;
        end else if (exec || state == DSW_ST_FLUSHING) begin
            o_pc <= o_pc + DSW_PC_STEP;
        end
    end

    // working register
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_work <= DSW_BYTE_ZERO;
        end else if ((op == DSW_OP_DEC || op == DSW_OP_DECSZ) && !dest_reg) begin
            o_work <= dec_result;
        end
    end

    // zero flag, touched only by plain decrement
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_zero_flag <= 1'b0;
        end else if (op == DSW_OP_DEC) begin
            o_zero_flag <= dec_zero;
        end
    end

    // status flags; kick wins over a sleep entry in the same cycle
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_watchdog_expiry_flag <= 1'b1;
            o_sleep_entry_flag     <= 1'b1;
        end else if (op == DSW_OP_KICK) begin
            o_watchdog_expiry_flag <= 1'b1;
            o_sleep_entry_flag     <= 1'b1;
        end else begin
            if (i_sleep_enter) begin
                o_sleep_entry_flag <= 1'b0;
            end
            if (o_watchdog_counter == DSW_BYTE_FULL && o_watchdog_prescaler == DSW_BYTE_FULL) begin
                o_watchdog_expiry_flag <= 1'b0;
            end
        end
    end

    // watchdog prescaler and counter
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_watchdog_counter   <= DSW_BYTE_ZERO;
            o_watchdog_prescaler <= DSW_BYTE_ZERO;
        end else if (op == DSW_OP_KICK) begin
            o_watchdog_counter   <= DSW_BYTE_ZERO;
            o_watchdog_prescaler <= DSW_BYTE_ZERO;
        end else begin
            o_watchdog_prescaler <= o_watchdog_prescaler + DSW_ONE;
            if (o_watchdog_prescaler == DSW_BYTE_FULL) begin
                o_watchdog_counter <= o_watchdog_counter + DSW_ONE;
            end
        end
    end

    // data register file; core write-back wins over a bus write
    always_ff @(posedge i_core_clk) begin
        if ((op == DSW_OP_DEC || op == DSW_OP_DECSZ) && dest_reg) begin
            data_regs[faddr] <= dec_result;
        end else if (bus_take && i_avs_write && i_avs_address == DSW_REG_FDATA) begin
            data_regs[findex] <= i_avs_writedata[DSW_DATA_W-1:0];
        end
    end

    // software-written latch and file index
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pc_upper_latch <= DSW_BYTE_ZERO;
            findex         <= '0;
        end else if (bus_take && i_avs_write) begin
            if (i_avs_address == DSW_REG_LATCH) begin
                pc_upper_latch <= i_avs_writedata[DSW_DATA_W-1:0];
            end
            if (i_avs_address == DSW_REG_FINDEX) begin
                findex <= i_avs_writedata[DSW_FADDR_W-1:0];
            end
        end
    end

    // bus handshake: one wait cycle, read data captured beside it
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= '0;
        end else begin
            o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
            if (i_avs_read && o_avs_waitrequest) begin
                unique case (i_avs_address)
                    DSW_REG_LATCH:  o_avs_readdata <= {24'h000000, pc_upper_latch};
                    DSW_REG_STATUS: o_avs_readdata <= {28'h0000000, o_flush, o_watchdog_expiry_flag,
                                                       o_sleep_entry_flag, o_zero_flag};
                    DSW_REG_WORK:   o_avs_readdata <= {24'h000000, o_work};
                    DSW_REG_PC:     o_avs_readdata <= {19'h00000, o_pc};
                    DSW_REG_WDOG:   o_avs_readdata <= {16'h0000, o_watchdog_prescaler, o_watchdog_counter};
                    DSW_REG_FINDEX: o_avs_readdata <= {25'h0000000, findex};
                    DSW_REG_FDATA:  o_avs_readdata <= {24'h000000, data_regs[findex]};
                    default:        o_avs_readdata <= '0;
                endcase
            end
        end
    end

    // checks
    property p_kick_clears_counter;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (op == DSW_OP_KICK) |=> (o_watchdog_counter == DSW_BYTE_ZERO);
    endproperty
    a_kick_clears_counter: assert property (p_kick_clears_counter)
        else $error("counter not cleared by kick");

    property p_kick_clears_prescaler;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (op == DSW_OP_KICK) |=> (o_watchdog_prescaler == DSW_BYTE_ZERO) && $stable(o_zero_flag);
    endproperty
    a_kick_clears_prescaler: assert property (p_kick_clears_prescaler)
        else $error("prescaler not cleared by kick");

    property p_kick_sets_flags;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (op == DSW_OP_KICK) |=> o_watchdog_expiry_flag && o_sleep_entry_flag && !o_flush;
    endproperty
    a_kick_sets_flags: assert property (p_kick_sets_flags)
        else $error("kick did not set both flags");

    property p_dec_zero_flag;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (op == DSW_OP_DEC) |=> (o_zero_flag == ($past(dec_result) == DSW_BYTE_ZERO));
    endproperty
    a_dec_zero_flag: assert property (p_dec_zero_flag)
        else $error("zero flag wrong after decrement");

    property p_dec_to_work;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        ((op == DSW_OP_DEC || op == DSW_OP_DECSZ) && !dest_reg) |=> (o_work == $past(data_regs[faddr]) - DSW_ONE);
    endproperty
    a_dec_to_work: assert property (p_dec_to_work)
        else $error("working register not loaded with decrement");

    property p_decsz_keeps_status;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (op == DSW_OP_DECSZ) |=> $stable(o_zero_flag) && $stable(o_watchdog_expiry_flag);
    endproperty
    a_decsz_keeps_status: assert property (p_decsz_keeps_status)
        else $error("decrement-skip changed a status flag");

    property p_skip_flush;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (op == DSW_OP_DECSZ) |=> (o_flush == $past(dec_zero)) ##1 !o_flush;
    endproperty
    a_skip_flush: assert property (p_skip_flush)
        else $error("skip did not flush exactly one slot");

    property p_jump_target;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (op == DSW_OP_JUMP) |=> (o_pc[DSW_JUMP_W-1:0] == $past(i_instr[DSW_JUMP_W-1:0]));
    endproperty
    a_jump_target: assert property (p_jump_target)
        else $error("jump target not loaded");

    property p_jump_two_cycles;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (op == DSW_OP_JUMP) |=> o_flush && (op == DSW_OP_NONE) && $stable(o_zero_flag) ##1 !o_flush;
    endproperty
    a_jump_two_cycles: assert property (p_jump_two_cycles)
        else $error("jump did not take two cycles");

    property p_bus_one_wait;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        ((i_avs_read || i_avs_write) && o_avs_waitrequest) |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
    endproperty
    a_bus_one_wait: assert property (p_bus_one_wait)
        else $error("bus answer not after one wait cycle");

    property p_jump_upper_bits;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (op == DSW_OP_JUMP) |=> (o_pc[DSW_PC_W-1:DSW_JUMP_W] == $past(pc_upper_latch[DSW_LATCH_HI:DSW_LATCH_LO]));
    endproperty
    a_jump_upper_bits: assert property (p_jump_upper_bits)
        else $error("jump upper pc bits not taken from latch");

    property p_dec_writes_file;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        ((op == DSW_OP_DEC || op == DSW_OP_DECSZ) && dest_reg) |=> (data_regs[$past(faddr)] == $past(dec_result));
    endproperty
    a_dec_writes_file: assert property (p_dec_writes_file)
        else $error("decrement result not written back to register");

    property p_dec_wraps;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        ((op == DSW_OP_DEC || op == DSW_OP_DECSZ) && !dest_reg && (data_regs[faddr] == DSW_BYTE_ZERO))
            |=> (o_work == DSW_BYTE_FULL);
    endproperty
    a_dec_wraps: assert property (p_dec_wraps)
        else $error("decrement of zero did not wrap");

    property p_skip_not_taken;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (op == DSW_OP_DECSZ && !dec_zero) |=> !o_flush && (o_pc == $past(o_pc) + DSW_PC_STEP);
    endproperty
    a_skip_not_taken: assert property (p_skip_not_taken)
        else $error("nonzero skip result did not run on");

    property p_flush_slot_ignored;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        o_flush |=> (o_pc == $past(o_pc) + DSW_PC_STEP) && $stable(o_work) && $stable(o_zero_flag);
    endproperty
    a_flush_slot_ignored: assert property (p_flush_slot_ignored)
        else $error("flushed slot was not a no-op");

    property p_sleep_clears;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_sleep_enter && op != DSW_OP_KICK) |=> !o_sleep_entry_flag;
    endproperty
    a_sleep_clears: assert property (p_sleep_clears)
        else $error("sleep entry did not clear its flag");

    property p_expiry_clears;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (op != DSW_OP_KICK && o_watchdog_counter == DSW_BYTE_FULL && o_watchdog_prescaler == DSW_BYTE_FULL)
            |=> !o_watchdog_expiry_flag;
    endproperty
    a_expiry_clears: assert property (p_expiry_clears)
        else $error("watchdog expiry did not clear its flag");

endmodule : dsw_core

`default_nettype wire

//--- bench/dsw_fetch_model.sv
// fetch stage and program memory model facing the execute block
// assumes the bench loads the program before raising i_run
`timescale 1ns/1ps
`default_nettype none

module dsw_fetch_model
    import dsw_pkg::*;
(
    // clock shared with the core
    input  wire logic                   i_clk,
    // control from the bench
    input  wire logic                   i_run,
    // program counter from the core
    input  wire logic [DSW_PC_W-1:0]    i_pc,
    // instruction presented to the core
    output logic      [DSW_INSTR_W-1:0] o_instr,
    output logic                        o_instr_valid
);
    logic [DSW_INSTR_W-1:0] prog [0:8191];

    // empty memory holds words that match no opcode
    initial begin
        for (int i = 0; i < 8192; i++) begin
            prog[i] = 14'h0000;
        end
    end

    // place one word in program memory
    task automatic load(input logic [DSW_PC_W-1:0] a, input logic [DSW_INSTR_W-1:0] w);
        prog[a] = w;
    endtask : load

    // registered prefetch: the word shown was fetched from the pc of the cycle before;
    // the first cycle after a start carries a blank word so the core steps pc once
    always_ff @(posedge i_clk) begin
        if (!i_run) begin
            o_instr       <= ~prog[i_pc];
            o_instr_valid <= 1'b0;
        end else if (!o_instr_valid) begin
            o_instr       <= 14'h0000;
            o_instr_valid <= 1'b1;
        end else begin
            o_instr       <= prog[i_pc];
            o_instr_valid <= 1'b1;
        end
    end
endmodule : dsw_fetch_model

`default_nettype wire

//--- bench/decrement_skip_jump_watchdog_ops_tb.sv
// self-checking bench for the execute block, program run from the fetch model
// assumes registers are loaded over avalon-mm before the program starts
`timescale 1ns/1ps
`default_nettype none

module decrement_skip_jump_watchdog_ops_tb;
    import dsw_pkg::*;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        run = 1'b0;
    logic        sleep_enter = 1'b0;
    logic [3:0]  av_addr = 4'h0;
    logic        av_rd = 1'b0;
    logic        av_wr = 1'b0;
    logic [31:0] av_wdata = 32'h0;
    logic [31:0] av_rdata, q;
    logic        av_wait, zf, exp_f, slp_f, flush;
    logic [13:0] instr;
    logic        instr_valid;
    logic [12:0] pc;
    logic [7:0]  work, wd_cnt, wd_pre;
    int          fail_count = 0;
    int          n_compared = 0;

    // clock at 40 MHz
    always #12.5 clk = ~clk;

    dsw_core u_dut (
        .i_core_clk(clk), .i_sys_rst(rst), .i_instr(instr), .i_instr_valid(instr_valid),
        .i_sleep_enter(sleep_enter), .i_avs_address(av_addr), .i_avs_read(av_rd),
        .i_avs_write(av_wr), .i_avs_writedata(av_wdata), .o_avs_readdata(av_rdata),
        .o_avs_waitrequest(av_wait), .o_pc(pc), .o_work(work), .o_zero_flag(zf),
        .o_watchdog_expiry_flag(exp_f), .o_sleep_entry_flag(slp_f),
        .o_watchdog_counter(wd_cnt), .o_watchdog_prescaler(wd_pre), .o_flush(flush));

    dsw_fetch_model u_fetch (.i_clk(clk), .i_run(run), .i_pc(pc), .o_instr(instr), .o_instr_valid(instr_valid));

    // verdict and end of run
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    // compare one value
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        av_rd    <= !wr;
        av_wr    <= wr;
        av_addr  <= a;
        av_wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (av_wait !== 1'b0 && n < 50);
        r = av_rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            $display("CHECK FAILED bus waitrequest expected 0 seen %b", av_wait);
            final_report();
        end
    endtask : bus

    // read one data register through index and data words
    task automatic file_rd(input logic [6:0] f, input logic [7:0] exp);
        bus(1'b1, DSW_REG_FINDEX, {25'h0, f}, q);
        bus(1'b0, DSW_REG_FDATA, 32'h0, q);
        chk("file register", {24'h0, exp}, q);
    endtask : file_rd

    // advance one core edge and let it settle
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("reset pc", 32'h0, {19'h0, pc});
        chk("reset flags", 32'h6, {28'h0, flush, exp_f, slp_f, zf});
        chk("reset waitrequest", 32'h1, {31'h0, av_wait});
        // load latch, data registers and program
        bus(1'b1, DSW_REG_LATCH, 32'h17, q);
        bus(1'b1, DSW_REG_FINDEX, 32'h5, q);  bus(1'b1, DSW_REG_FDATA, 32'h01, q);
        bus(1'b1, DSW_REG_FINDEX, 32'hA, q);  bus(1'b1, DSW_REG_FDATA, 32'h02, q);
        bus(1'b1, DSW_REG_FINDEX, 32'h7F, q); bus(1'b1, DSW_REG_FDATA, 32'h00, q);
        bus(1'b1, DSW_REG_FINDEX, 32'h3, q);  bus(1'b1, DSW_REG_FDATA, 32'h01, q);
        u_fetch.load(13'h0000, 14'h0385); u_fetch.load(13'h0001, 14'h0064);
        u_fetch.load(13'h0002, 14'h0B8A); u_fetch.load(13'h0003, 14'h037F);
        u_fetch.load(13'h0004, 14'h0B03); u_fetch.load(13'h0005, 14'h038A);
        u_fetch.load(13'h0006, 14'h28A5); u_fetch.load(13'h10A5, 14'h038A);
        u_fetch.load(13'h0007, 14'h0385);
        // wait for the watchdog to expire, then let it count again before the kick
        for (int n = 0; n < 70000 && exp_f !== 1'b0; n++) begin
            @(posedge clk);
        end
        chk("expiry before kick", 32'h0, {31'h0, exp_f});
        if (exp_f !== 1'b0) begin
            final_report();
        end
        repeat (600) @(posedge clk);
        // first executed slot is the primed blank word, program word 0 follows
        run         <= 1'b1;
        sleep_enter <= 1'b1;
        @(posedge clk);
        sleep_enter <= 1'b0;
        #1;
        chk("sleep flag cleared", 32'h0, {31'h0, slp_f});
        tick();
        tick();
        chk("dec zero flag", 32'h1, {31'h0, zf});
        tick();
        chk("kick counter", 32'h0, {24'h0, wd_cnt});
        chk("kick prescaler", 32'h0, {24'h0, wd_pre});
        chk("kick flags", 32'h7, {28'h0, flush, exp_f, slp_f, zf});
        tick();
        chk("skip not taken", 32'h4, {18'h0, flush, pc});
        chk("skip keeps zero", 32'h1, {31'h0, zf});
        tick();
        chk("wrap to work", 32'h0FF, {23'h0, zf, work});
        tick();
        chk("skip taken", 32'h2006, {18'h0, flush, pc});
        chk("skip to work", 32'h000, {23'h0, zf, work});
        tick();
        chk("skip slot done", 32'h7, {18'h0, flush, pc});
        tick();
        chk("jump target", 32'h30A5, {18'h0, flush, pc});
        chk("jump keeps zero", 32'h0, {31'h0, zf});
        tick();
        chk("jump slot done", 32'h10A6, {18'h0, flush, pc});
        tick();
        chk("target executed", 32'h10A7, {18'h0, flush, pc});
        chk("target zero flag", 32'h1, {31'h0, zf});
        @(posedge clk);
        run <= 1'b0;
        $display("program sequence done");
        // results left in the register file and readback
        file_rd(7'h05, 8'h00);
        file_rd(7'h0A, 8'h00);
        file_rd(7'h7F, 8'h00);
        file_rd(7'h03, 8'h01);
        bus(1'b0, DSW_REG_LATCH, 32'h0, q);
        chk("latch readback", 32'h17, q);
        bus(1'b0, DSW_REG_WORK, 32'h0, q);
        chk("work readback", 32'h0, q);
        bus(1'b0, 4'hF, 32'h0, q);
        chk("unmapped read", 32'h0, q);
        $display("register readback done");
        final_report();
    end
endmodule : decrement_skip_jump_watchdog_ops_tb

`default_nettype wire
